// File: hdl/dcc_pkg.sv
package dcc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned CYCLE_MS   = 100;
  localparam int unsigned CYCLE_CYC  = CYCLE_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W      = 23;

  // ----------------------------------------------------------------
  // frame identifiers and layout
  // ----------------------------------------------------------------
  localparam logic [10:0] ID_VEH_FAULT = 11'h102;
  localparam logic [10:0] ID_STN_CAP   = 11'h108;
  localparam logic [10:0] ID_STN_STAT  = 11'h109;
  localparam logic [3:0]  FRAME_DLC    = 4'h8;
  localparam logic [3:0]  RX_MIN_DLC   = 4'h6;
  localparam int unsigned FRM_W        = 11 + 4 + 64;

  // frame 108 byte positions
  localparam int unsigned B108_WELD    = 0;
  localparam int unsigned B108_VAVAIL  = 1;
  localparam int unsigned B108_IAVAIL  = 3;
  localparam int unsigned B108_VTHRESH = 4;
  // frame 109 byte positions
  localparam int unsigned B109_PROTO   = 0;
  localparam int unsigned B109_VOUT    = 1;
  localparam int unsigned B109_IOUT    = 3;
  localparam int unsigned B109_STAT    = 5;
  localparam int unsigned B109_REM10S  = 6;
  localparam int unsigned B109_REMMIN  = 7;
  // frame 109 status byte bits
  localparam int unsigned S_CHARGING   = 0;
  localparam int unsigned S_FAULT      = 1;
  localparam int unsigned S_LOCKED     = 2;
  localparam int unsigned S_INCOMPAT   = 3;
  localparam int unsigned S_VEH_PROB   = 4;
  localparam int unsigned S_STOPPING   = 5;
  // frame 102 positions
  localparam int unsigned B102_FAULT   = 4;
  localparam int unsigned B102_STAT    = 5;
  localparam int unsigned F_CURR_DEV   = 2;
  localparam int unsigned F_TEMP_HIGH  = 3;
  localparam int unsigned F_VOLT_DEV   = 4;
  localparam int unsigned F_CHG_EN     = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [63:0] DATA_RST = 64'h0000_0000_0000_0000;
  localparam logic        FLAG_RST = 1'b0;

endpackage

// File: hdl/dcc_skid_buf.sv
`timescale 1ns/1ps
module dcc_skid_buf (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // filling side
  input  wire logic                     in_valid,
  input  wire logic [dcc_pkg::FRM_W-1:0] in_data,
  output logic                          in_ready,
  // draining side
  output logic                          out_valid,
  output logic [dcc_pkg::FRM_W-1:0]      out_data,
  input  wire logic                     out_ready
);

  // ----------------------------------------------------------------
  // state: output stage plus one skid entry
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                     out_valid;
    logic [dcc_pkg::FRM_W-1:0] out_data;
    logic                     skid_valid;
    logic [dcc_pkg::FRM_W-1:0] skid_data;
  } dcc_buf_t;

  dcc_buf_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    if (s_reg.out_valid && out_ready) begin
      s_next.out_valid  = s_reg.skid_valid;
      s_next.out_data   = s_reg.skid_data;
      s_next.skid_valid = 1'b0;
    end
    // ready is registered, so a write only arrives while the skid is free
    if (in_valid && !s_reg.skid_valid) begin
      if (!s_next.out_valid) begin
        s_next.out_valid = 1'b1;
        s_next.out_data  = in_data;
      end else begin
        s_next.skid_valid = 1'b1;
        s_next.skid_data  = in_data;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready  = !s_reg.skid_valid;
  assign out_valid = s_reg.out_valid;
  assign out_data  = s_reg.out_data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_hold_stall;
    @(posedge clk) disable iff (!resetn)
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_hold_stall: assert property (p_hold_stall)
    else $error("buffer dropped a stalled word");

  property p_full_refuses;
    @(posedge clk) disable iff (!resetn)
    s_reg.skid_valid |-> !in_ready && out_valid;
  endproperty
  a_full_refuses: assert property (p_full_refuses)
    else $error("buffer full but still ready");

endmodule

// File: hdl/dcc_rx_parse.sv
`timescale 1ns/1ps
module dcc_rx_parse (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // received frame
  input  wire logic        rx_valid,
  input  wire logic [10:0] rx_id,
  input  wire logic        rx_ide,
  input  wire logic        rx_error,
  input  wire logic [3:0]  rx_dlc,
  input  wire logic [63:0] rx_data,
  // held vehicle flags, plus a one-cycle frame-seen pulse
  output logic             veh_curr_dev,
  output logic             veh_temp_high,
  output logic             veh_volt_dev,
  output logic             veh_chg_enable,
  output logic             veh_frame_seen
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic curr_dev;
    logic temp_high;
    logic volt_dev;
    logic chg_en;
    logic seen;
  } dcc_rx_t;

  dcc_rx_t s_reg, s_next;
  logic    good;

  // error frames, extended ids and short frames never touch the flags
  assign good = rx_valid && !rx_error && !rx_ide &&
                rx_id == dcc_pkg::ID_VEH_FAULT &&
                rx_dlc >= dcc_pkg::RX_MIN_DLC;

  always_comb begin
    s_next      = s_reg;
    s_next.seen = good;
    if (good) begin
      // only the assigned bits are picked out; the rest are ignored
      s_next.curr_dev  = rx_data[8*dcc_pkg::B102_FAULT +
                                 dcc_pkg::F_CURR_DEV];
      s_next.temp_high = rx_data[8*dcc_pkg::B102_FAULT +
                                 dcc_pkg::F_TEMP_HIGH];
      s_next.volt_dev  = rx_data[8*dcc_pkg::B102_FAULT +
                                 dcc_pkg::F_VOLT_DEV];
      s_next.chg_en    = rx_data[8*dcc_pkg::B102_STAT +
                                 dcc_pkg::F_CHG_EN];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign veh_curr_dev   = s_reg.curr_dev;
  assign veh_temp_high  = s_reg.temp_high;
  assign veh_volt_dev   = s_reg.volt_dev;
  assign veh_chg_enable = s_reg.chg_en;
  assign veh_frame_seen = s_reg.seen;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_err_ignored;
    @(posedge clk) disable iff (!resetn)
    rx_valid && rx_error |=> $stable({veh_curr_dev, veh_temp_high,
                                      veh_volt_dev, veh_chg_enable});
  endproperty
  a_err_ignored: assert property (p_err_ignored)
    else $error("error frame changed a vehicle flag");

  property p_flag_taken;
    @(posedge clk) disable iff (!resetn)
    good |=> veh_temp_high == $past(rx_data[35]) && veh_frame_seen;
  endproperty
  a_flag_taken: assert property (p_flag_taken)
    else $error("temperature flag not taken from frame");

endmodule

// File: hdl/dcc_codec.sv
`timescale 1ns/1ps
// What this block does
// - frame 108 byte 0: welding-detection support, zero means unsupported
// - frame 108 bytes 1-2 carry maximum available voltage, 1 V per count
// - frame 108 byte 3 carries maximum available current, 1 A per count
// - frame 108 bytes 4-5 carry battery-protection stop threshold voltage
// - frame 109 byte 0 carries supported control protocol number
// - frame 109 bytes 1-2 carry present output voltage, 1 V per count
// - frame 109 byte 3 carries present output current, 1 A per count
// - frame 109 byte 6 carries remaining time in 10 s units
// - frame 109 byte 7 carries remaining time in minutes
// - frame 109 byte 5 bit 0: 0 standby, 1 transferring energy
// - frame 109 byte 5 bit 1: station fault detected
// - frame 109 byte 5 bit 2: connector lock engaged
// - frame 109 byte 5 bit 3: vehicle battery incompatible
// - frame 109 byte 5 bit 4: vehicle-side problem detected
// - frame 109 byte 5 bit 5: shutting down or stopping
// - standard 11-bit identifiers only, link at 500 kbit/s
// - frames of one cycle go out in ascending identifier order
// - frames repeat every 100 ms throughout charging
// - received frames are never echoed back
// - error frames are discarded and update nothing
module dcc_codec #(
  parameter int unsigned PERIOD_CYC = dcc_pkg::CYCLE_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // charging session
  input  wire logic        session_active,
  // station capability
  input  wire logic [7:0]  weld_detect_support,
  input  wire logic [15:0] avail_volt,
  input  wire logic [7:0]  avail_curr,
  input  wire logic [15:0] thresh_volt,
  input  wire logic [7:0]  proto_num,
  // station measurements
  input  wire logic [15:0] out_volt,
  input  wire logic [7:0]  out_curr,
  input  wire logic [7:0]  remain_10s,
  input  wire logic [7:0]  remain_min,
  // station status
  input  wire logic        st_charging,
  input  wire logic        st_fault,
  input  wire logic        st_locked,
  input  wire logic        st_incompat,
  input  wire logic        st_veh_problem,
  input  wire logic        st_stopping,
  // frame to link controller
  output logic             tx_valid,
  output logic [10:0]      tx_id,
  output logic             tx_ide,
  output logic [3:0]       tx_dlc,
  output logic [63:0]      tx_data,
  input  wire logic        tx_ready,
  // frame from link controller
  input  wire logic        rx_valid,
  input  wire logic [10:0] rx_id,
  input  wire logic        rx_ide,
  input  wire logic        rx_error,
  input  wire logic [3:0]  rx_dlc,
  input  wire logic [63:0] rx_data,
  // vehicle flags
  output logic             veh_curr_dev,
  output logic             veh_temp_high,
  output logic             veh_volt_dev,
  output logic             veh_chg_enable,
  output logic             veh_frame_seen,
  // cycle status
  output logic             cycle_overrun
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_S108 = 2'b01,
    ST_S109 = 2'b10
  } dcc_st_t;

  typedef struct packed {
    dcc_st_t                  st;
    logic [dcc_pkg::CNT_W-1:0] cnt;
    logic                     pend;
    logic                     active_d;
    logic                     ide;
    logic                     overrun;
  } dcc_top_t;

  localparam logic [dcc_pkg::CNT_W-1:0] CNT_LAST =
    dcc_pkg::CNT_W'(PERIOD_CYC - 1);

  dcc_top_t                  s_reg, s_next;
  logic [63:0]               data108;
  logic [63:0]               data109;
  logic [7:0]                stat_byte;
  logic                      push;
  logic                      buf_in_ready;
  logic [dcc_pkg::FRM_W-1:0] frame_in;
  logic [dcc_pkg::FRM_W-1:0] frame_out;
  logic                      tick;

  // ----------------------------------------------------------------
  // frame contents
  // ----------------------------------------------------------------
  // multi-byte values go low byte first
  always_comb begin
    data108 = dcc_pkg::DATA_RST;
    data108[8*dcc_pkg::B108_WELD +: 8]     = weld_detect_support;
    data108[8*dcc_pkg::B108_VAVAIL +: 16]  = avail_volt;
    data108[8*dcc_pkg::B108_IAVAIL +: 8]   = avail_curr;
    data108[8*dcc_pkg::B108_VTHRESH +: 16] = thresh_volt;
  end

  always_comb begin
    stat_byte = 8'h00;
    stat_byte[dcc_pkg::S_CHARGING] = st_charging;
    stat_byte[dcc_pkg::S_FAULT]    = st_fault;
    stat_byte[dcc_pkg::S_LOCKED]   = st_locked;
    stat_byte[dcc_pkg::S_INCOMPAT] = st_incompat;
    stat_byte[dcc_pkg::S_VEH_PROB] = st_veh_problem;
    stat_byte[dcc_pkg::S_STOPPING] = st_stopping;
  end

  always_comb begin
    data109 = dcc_pkg::DATA_RST;
    data109[8*dcc_pkg::B109_PROTO +: 8]  = proto_num;
    data109[8*dcc_pkg::B109_VOUT +: 16]  = out_volt;
    data109[8*dcc_pkg::B109_IOUT +: 8]   = out_curr;
    data109[8*dcc_pkg::B109_STAT +: 8]   = stat_byte;
    data109[8*dcc_pkg::B109_REM10S +: 8] = remain_10s;
    data109[8*dcc_pkg::B109_REMMIN +: 8] = remain_min;
  end

  // only frames built here enter the transmit path, never received ones
  always_comb begin
    if (s_reg.st == ST_S109) begin
      frame_in = {dcc_pkg::ID_STN_STAT, dcc_pkg::FRAME_DLC, data109};
    end else begin
      frame_in = {dcc_pkg::ID_STN_CAP, dcc_pkg::FRAME_DLC, data108};
    end
  end

  assign push = (s_reg.st != ST_IDLE) && buf_in_ready;
  assign tick = session_active && s_reg.cnt == CNT_LAST;

  // ----------------------------------------------------------------
  // cycle timer and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_next          = s_reg;
    s_next.active_d = session_active;
    s_next.ide      = 1'b0;
    if (!session_active) begin
      s_next.cnt  = '0;
      s_next.pend = 1'b0;
    end else if (!s_reg.active_d) begin
      // first cycle goes out at once when the session starts
      s_next.cnt  = '0;
      s_next.pend = 1'b1;
    end else if (tick) begin
      s_next.cnt  = '0;
      s_next.pend = 1'b1;
      // a cycle still waiting means the link stalled for a whole period
      s_next.overrun = s_reg.pend || s_reg.st != ST_IDLE;
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
    case (s_reg.st)
      ST_IDLE: begin
        if (s_reg.pend && session_active) begin
          s_next.st   = ST_S108;
          s_next.pend = tick;
        end
      end
      ST_S108: begin
        if (push) begin
          s_next.st = ST_S109;
        end
      end
      ST_S109: begin
        if (push) begin
          s_next.st = ST_IDLE;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer and receive side
  // ----------------------------------------------------------------
  // two entries let a receiver stall for a frame without losing 109
  dcc_skid_buf u_buf (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (s_reg.st != ST_IDLE),
    .in_data   (frame_in),
    .in_ready  (buf_in_ready),
    .out_valid (tx_valid),
    .out_data  (frame_out),
    .out_ready (tx_ready)
  );

  dcc_rx_parse u_rx (
    .clk            (clk),
    .resetn         (resetn),
    .rx_valid       (rx_valid),
    .rx_id          (rx_id),
    .rx_ide         (rx_ide),
    .rx_error       (rx_error),
    .rx_dlc         (rx_dlc),
    .rx_data        (rx_data),
    .veh_curr_dev   (veh_curr_dev),
    .veh_temp_high  (veh_temp_high),
    .veh_volt_dev   (veh_volt_dev),
    .veh_chg_enable (veh_chg_enable),
    .veh_frame_seen (veh_frame_seen)
  );

  assign tx_id         = frame_out[dcc_pkg::FRM_W-1 -: 11];
  assign tx_dlc        = frame_out[67:64];
  assign tx_data       = frame_out[63:0];
  assign tx_ide        = s_reg.ide;
  assign cycle_overrun = s_reg.overrun;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_push108;
    s_reg.st == ST_S108 && push;
  endsequence

  sequence s_push109;
    s_reg.st == ST_S109 && push;
  endsequence

  property p_std_id;
    tx_valid |-> !tx_ide && tx_dlc == dcc_pkg::FRAME_DLC &&
                 (tx_id == dcc_pkg::ID_STN_CAP ||
                  tx_id == dcc_pkg::ID_STN_STAT);
  endproperty
  a_std_id: assert property (p_std_id)
    else $error("transmitted frame not standard id of station");

  property p_order;
    s_push108 |=> s_reg.st == ST_S109 ##[0:8] s_push109;
  endproperty
  a_order: assert property (p_order)
    else $error("frame 109 did not follow frame 108");

  property p_tick;
    tick && s_reg.active_d |=> s_reg.cnt == '0 &&
                               (s_reg.pend || s_reg.st == ST_S108);
  endproperty
  a_tick: assert property (p_tick)
    else $error("period end did not start a cycle");

  property p_cnt_bound;
    s_reg.cnt <= CNT_LAST;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("period counter ran past its last count");

  property p_start;
    $rose(session_active) ##1 1'b1 |=> s_reg.st == ST_S108;
  endproperty
  a_start: assert property (p_start)
    else $error("session start did not send a cycle");

  property p_stat_zero;
    s_push109 |-> frame_in[8*dcc_pkg::B109_STAT + 6 +: 2] == 2'b00 &&
                  frame_in[8*dcc_pkg::B109_STAT + 5] == st_stopping;
  endproperty
  a_stat_zero: assert property (p_stat_zero)
    else $error("status byte of 109 wrong");

  property p_map108;
    s_push108 |-> frame_in[8*dcc_pkg::B108_IAVAIL +: 8] == avail_curr &&
                  frame_in[8*dcc_pkg::B108_VTHRESH +: 16] == thresh_volt;
  endproperty
  a_map108: assert property (p_map108)
    else $error("frame 108 fields misplaced");

  property p_map109;
    s_push109 |-> frame_in[8*dcc_pkg::B109_REMMIN +: 8] == remain_min &&
                  frame_in[8*dcc_pkg::B109_STAT] == st_charging;
  endproperty
  a_map109: assert property (p_map109)
    else $error("frame 109 fields misplaced");

endmodule

// File: tb/dcc_link_model.sv
`timescale 1ns/1ps
module dcc_link_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // behaviour: 0 prompt, 1 random stalls, 2 stalled
  input  wire logic [1:0]  mode,
  // codec transmit side
  output logic             tx_ready,
  // codec receive side
  output logic             rx_valid,
  output logic [10:0]      rx_id,
  output logic             rx_ide,
  output logic             rx_error,
  output logic [3:0]       rx_dlc,
  output logic [63:0]      rx_data
);
  initial begin
    rx_valid = 1'b0;
    rx_id    = 11'h000;
    rx_ide   = 1'b0;
    rx_error = 1'b0;
    rx_dlc   = 4'h0;
    rx_data  = 64'h0000_0000_0000_0000;
  end

  // stalls only as the bench commands; a stalled link may hold off forever
  always @(negedge clk) begin
    if (!resetn)
      tx_ready <= 1'b0;
    else if (mode == 2'h0)
      tx_ready <= 1'b1;
    else if (mode == 2'h1)
      tx_ready <= 1'($urandom_range(1));
    else
      tx_ready <= 1'b0;
  end

  // one frame per call, left driven so calls may run back to back
  task send_rx(input logic [10:0] id, input logic ide, input logic err,
               input logic [3:0] dlc, input logic [63:0] data);
    rx_valid = 1'b1;
    rx_id    = id;
    rx_ide   = ide;
    rx_error = err;
    rx_dlc   = dlc;
    rx_data  = data;
    @(negedge clk);
  endtask

  // idle lines show each field inverted with rx_valid low; a second idle in a row restores the last frame's fields but keeps rx_valid low
  task rx_idle;
    rx_valid = 1'b0;
    rx_id    = ~rx_id;
    rx_ide   = ~rx_ide;
    rx_error = ~rx_error;
    rx_dlc   = ~rx_dlc;
    rx_data  = ~rx_data;
    @(negedge clk);
  endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int unsigned PER = 50;
  logic clk, resetn, session_active, tx_ready, tx_valid, tx_ide;
  logic [7:0] weld, avail_curr, proto_num, out_curr, rem10, remmin;
  logic [15:0] avail_volt, thresh_volt, out_volt;
  logic [5:0] st;
  logic [1:0] mode;
  logic [10:0] tx_id, rx_id, last_id, pend_id;
  logic [3:0] tx_dlc, rx_dlc;
  logic [63:0] tx_data, rx_data, d, x109;
  logic rx_valid, rx_ide, rx_error, pend;
  logic v_curr, v_temp, v_volt, v_en, v_seen, overrun;
  logic [4:0] e_flags, o_flags;
  int miscompares, checked, cyc, last108, n109, k, q;

  // ------------------------------------------------------------
  // clock and instances
  // ------------------------------------------------------------
  initial clk = 1'b0;
  always #10 clk = ~clk;

  dcc_codec #(.PERIOD_CYC(PER)) DUT (
    .clk(clk), .resetn(resetn), .session_active(session_active),
    .weld_detect_support(weld), .avail_volt(avail_volt),
    .avail_curr(avail_curr), .thresh_volt(thresh_volt),
    .proto_num(proto_num), .out_volt(out_volt), .out_curr(out_curr),
    .remain_10s(rem10), .remain_min(remmin), .st_charging(st[0]),
    .st_fault(st[1]), .st_locked(st[2]), .st_incompat(st[3]),
    .st_veh_problem(st[4]), .st_stopping(st[5]), .tx_valid(tx_valid),
    .tx_id(tx_id), .tx_ide(tx_ide), .tx_dlc(tx_dlc), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_id(rx_id),
    .rx_ide(rx_ide), .rx_error(rx_error), .rx_dlc(rx_dlc),
    .rx_data(rx_data), .veh_curr_dev(v_curr), .veh_temp_high(v_temp),
    .veh_volt_dev(v_volt), .veh_chg_enable(v_en),
    .veh_frame_seen(v_seen), .cycle_overrun(overrun));

  dcc_link_model u_link (
    .clk(clk), .resetn(resetn), .mode(mode), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_id(rx_id), .rx_ide(rx_ide),
    .rx_error(rx_error), .rx_dlc(rx_dlc), .rx_data(rx_data));

  assign o_flags = {v_curr, v_temp, v_volt, v_en, v_seen};

  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function logic [63:0] exp108;
    return {16'h0000, thresh_volt, avail_curr, avail_volt, weld};
  endfunction

  function logic [63:0] exp109;
    return {remmin, rem10, 2'b00, st, 8'h00, out_curr, out_volt, proto_num};
  endfunction

  always @(posedge clk) begin
    cyc++;
    if (resetn && pend)
      check(64'({tx_valid, tx_id}), 64'({1'b1, pend_id}));
    pend = tx_valid && !tx_ready;
    pend_id = tx_id;
    if (tx_valid && tx_ready) begin
      check(64'({tx_ide, tx_dlc}), 64'h0000_0000_0000_0008);
      if (tx_id == dcc_pkg::ID_STN_CAP) begin
        check(64'(last_id != dcc_pkg::ID_STN_CAP), 64'h1);
        check(tx_data, exp108());
        if (last108 >= 0 && mode == 2'h0)
          check(64'(cyc - last108), 64'(PER));
        last108 = cyc;
      end else begin
        check(64'(last_id), 64'(dcc_pkg::ID_STN_CAP));
        x109 = exp109();
        check(tx_data, x109);
        n109++;
      end
      last_id = tx_id;
    end
    // the ceiling is last so that nothing runs after the verdict
    if (cyc >= 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  task wait_frames(input int n);
    k = n109 + n;
    while (n109 < k)
      @(negedge clk);
  endtask

  task rand_inputs;
    weld = 8'($urandom_range(3));
    avail_volt = 16'($urandom_range(600));
    thresh_volt = 16'($urandom_range(600));
    out_volt = 16'($urandom_range(600));
    {avail_curr, proto_num, out_curr, rem10} = $urandom;
    remmin = 8'($urandom);
    st = 6'($urandom);
  endtask

  initial begin
    void'($urandom(34));
    {resetn, session_active, mode, pend, last_id, st} = '0;
    {weld, avail_curr, proto_num, out_curr, rem10, remmin} = '0;
    {avail_volt, thresh_volt, out_volt} = '0;
    {miscompares, checked, cyc, n109} = '0;
    last108 = -1;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check(tx_data, 64'h0000_0000_0000_0000);
    check(64'({tx_valid, tx_id, v_curr, v_temp, v_volt, v_en, overrun}),
          64'h0000_0000_0000_0000);
    e_flags = 5'h00;
    for (int i = 0; i < 60; i++) begin
      k = (i < 6) ? i : $urandom_range(5);
      d = {$urandom, $urandom};
      if (k == 1)
        d[40:32] = 9'h1ff;
      u_link.send_rx((k == 4) ? 11'h109 : 11'h102, k == 3, k == 2,
                     (k == 5) ? 4'(i % 6) : 4'(i % 3 + 6), d);
      if (k < 2)
        e_flags = {d[34], d[35], d[36], d[40], 1'b1};
      else
        e_flags[0] = 1'b0;
      check(64'(o_flags), 64'(e_flags));
      check(64'(tx_valid), 64'h0);
      if ($urandom_range(1))
        u_link.rx_idle();
    end
    u_link.rx_idle();
    {avail_volt, thresh_volt, out_volt} = {3{16'h0258}};
    {weld, avail_curr, proto_num, out_curr, rem10, remmin} = '1;
    st = 6'h3f;
    session_active = 1'b1;
    repeat (4) @(negedge clk);
    check(64'(tx_valid), 64'h1);
    for (int i = 0; i < 6; i++) begin
      wait_frames(1);
      rand_inputs();
    end
    mode = 2'h1;
    wait_frames(4);
    mode = 2'h2;
    repeat (3 * PER + 5) @(negedge clk);
    check(64'(overrun), 64'h1);
    mode = 2'h0;
    // queued cycles leave back to back, so their spacing is not judged
    repeat (3) begin
      last108 = -1;
      wait_frames(1);
    end
    last108 = -1;
    wait_frames(2);
    check(64'(overrun), 64'h0);
    session_active = 1'b0;
    repeat (5) @(negedge clk);
    q = 0;
    repeat (3 * PER) begin
      @(negedge clk);
      if (tx_valid !== 1'b0)
        q++;
    end
    check(64'(q), 64'h0);
    last_id = 11'h000;
    last108 = -1;
    session_active = 1'b1;
    wait_frames(2);
    print_verdict();
  end
endmodule
